//--- verilog/autoneg_adv_pkg.sv
// Purpose: Constants for the auto-negotiation advertisement register bank
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
package autoneg_adv_pkg;
  // Byte offsets
  localparam logic [3:0] ADDR_ADV    = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Advertisement field positions
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_ACK       = 14;
  localparam int ADV_FAULT     = 13;
  localparam int ADV_RSV_HI    = 12;
  localparam int ADV_RSV_LO    = 10;
  localparam int ADV_T4        = 9;
  localparam int ADV_TECH_HI   = 8;
  localparam int ADV_TECH_LO   = 5;
  localparam int ADV_SEL_HI    = 4;
  // Control field positions
  localparam int CTRL_OVERRIDE = 15;
  localparam int CTRL_RATE     = 13;
  localparam int CTRL_AN_EN    = 12;
  localparam int CTRL_RESTART  = 9;
  localparam int CTRL_DUPLEX   = 8;
  // Reset values
  localparam logic       RST_NEXT_PAGE = 1'b0;
  localparam logic [2:0] RST_RSV       = 3'h0;
  localparam logic [3:0] RST_TECH_SW   = 4'hF;
  localparam logic [4:0] RST_SELECTOR  = 5'h01;
  localparam logic       RST_OVERRIDE  = 1'b0;
  localparam logic       RST_AN_EN     = 1'b1;
  localparam logic       RST_RATE      = 1'b1;
  localparam logic       RST_DUPLEX    = 1'b1;
  // Full capability set reported in status
  localparam logic [3:0] FULL_CAPS     = 4'hF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

//--- verilog/autoneg_adv_regs.sv
// Purpose: Local auto-negotiation advertisement register with AXI4-Lite
// Assumes: Mode and fault pins are asynchronous and synchronised here
// Notes: Code word abilities latch at reset and restart in software mode
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module autoneg_adv_regs
  import autoneg_adv_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Strap and fault pins
  input  wire logic        hardware_software_mode_pin,
  input  wire logic        autoneg_select_pin,
  input  wire logic        rate_select_pin,
  input  wire logic        duplex_select_pin,
  input  wire logic        local_link_fault,
  // Towards the negotiation logic
  output logic [15:0]      link_code_word,
  output logic             autoneg_active,
  output logic             autoneg_restart,
  output logic             idle_mode,
  output logic             op_speed_100,
  output logic             op_full_duplex
);

  // Pin synchronisers
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge sys_clk) begin
    pin_meta <= {local_link_fault, duplex_select_pin, rate_select_pin,
                 autoneg_select_pin, hardware_software_mode_pin};
    pin_sync <= pin_meta;
  end
  logic sw_mode;
  logic an_pin;
  logic rate_pin;
  logic dpx_pin;
  logic fault_s;
  assign sw_mode  = pin_sync[0];
  assign an_pin   = pin_sync[1];
  assign rate_pin = pin_sync[2];
  assign dpx_pin  = pin_sync[3];
  assign fault_s  = pin_sync[4];
  // Register state
  logic       next_page;
  logic       rsv_ack;
  logic       remote_fault;
  logic [2:0] rsv_hi;
  logic [3:0] tech;
  logic [4:0] selector;
  logic       override;
  logic       an_enable;
  logic       rate_sel;
  logic       duplex_sel;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0] = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction

  function automatic logic mapped(input logic [3:0] a);
    return (a == ADDR_ADV) || (a == ADDR_CTRL) || (a == ADDR_STATUS);
  endfunction

  // Write channel
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 4'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic        wr_adv;
  logic        wr_ctrl;
  logic [15:0] adv_new;
  logic [15:0] ctrl_new;
  logic [15:0] adv_view;
  logic [15:0] ctrl_view;
  assign wr_adv   = wr_fire && (aw_addr_q == ADDR_ADV);
  assign wr_ctrl  = wr_fire && (aw_addr_q == ADDR_CTRL);
  assign adv_new  = merge16(adv_view, wdata_q, wstrb_q);
  assign ctrl_new = merge16(ctrl_view, wdata_q, wstrb_q);

  // Stored view including hidden reserved contents
  assign adv_view = {next_page, rsv_ack, remote_fault, rsv_hi, 1'b0, tech,
                     selector};
  assign ctrl_view = {override, 1'b0, rate_sel, an_enable, 3'h0,
                      duplex_sel, 8'h00};

  // Plain read/write next page bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      next_page <= RST_NEXT_PAGE;
    end else if (wr_adv) begin
      next_page <= adv_new[ADV_NEXT_PAGE];
    end
  end

  // Override-write reserved and selector bits
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsv_ack  <= 1'b0;
      rsv_hi   <= RST_RSV;
      selector <= RST_SELECTOR;
    end else if (wr_adv && override) begin
      rsv_ack  <= adv_new[ADV_ACK];
      rsv_hi   <= adv_new[ADV_RSV_HI:ADV_RSV_LO];
      selector <= adv_new[ADV_SEL_HI:0];
    end
  end

  // Remote fault tracks the local fault detector
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      remote_fault <= 1'b0;
    end else begin
      remote_fault <= fault_s;
    end
  end

  // Ability bits, mode dependent
  logic [3:0] pin_onehot;
  assign pin_onehot = 4'(4'h1 << {rate_pin, dpx_pin});
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tech <= RST_TECH_SW;
    end else if (!sw_mode) begin
      tech <= an_pin ? pin_onehot : 4'h0;
    end else if (wr_adv && override) begin
      tech <= adv_new[ADV_TECH_HI:ADV_TECH_LO];
    end
  end

  // Control register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      override   <= RST_OVERRIDE;
      an_enable  <= RST_AN_EN;
      rate_sel   <= RST_RATE;
      duplex_sel <= RST_DUPLEX;
    end else if (wr_ctrl) begin
      override   <= ctrl_new[CTRL_OVERRIDE];
      an_enable  <= ctrl_new[CTRL_AN_EN];
      rate_sel   <= ctrl_new[CTRL_RATE];
      duplex_sel <= ctrl_new[CTRL_DUPLEX];
    end
  end

  // Restart pulse, also issued once after reset
  logic boot;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      boot            <= 1'b1;
      autoneg_restart <= 1'b0;
    end else begin
      boot            <= 1'b0;
      autoneg_restart <= boot || (wr_ctrl && wstrb_q[1] &&
                                  wdata_q[CTRL_RESTART]);
    end
  end

  // Operating mode selection
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      autoneg_active <= 1'b0;
      idle_mode      <= 1'b0;
      op_speed_100   <= 1'b0;
      op_full_duplex <= 1'b0;
    end else begin
      autoneg_active <= sw_mode ? an_enable : an_pin;
      idle_mode      <= sw_mode ? !an_enable : !an_pin;
      op_speed_100   <= sw_mode ? rate_sel : rate_pin;
      op_full_duplex <= sw_mode ? duplex_sel : dpx_pin;
    end
  end

  // Code word abilities latch on restart in software mode
  logic [2:0] lcw_rsv;
  logic [3:0] lcw_tech;
  logic [4:0] lcw_sel;
  logic       lcw_np;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lcw_np   <= RST_NEXT_PAGE;
      lcw_rsv  <= RST_RSV;
      lcw_tech <= RST_TECH_SW;
      lcw_sel  <= RST_SELECTOR;
    end else if (autoneg_restart || !sw_mode) begin
      lcw_np   <= next_page;
      lcw_rsv  <= rsv_hi;
      lcw_tech <= tech;
      lcw_sel  <= selector;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link_code_word <= {RST_NEXT_PAGE, 2'b00, RST_RSV, 1'b0, RST_TECH_SW,
                         RST_SELECTOR};
    end else begin
      link_code_word <= {lcw_np, 1'b0, remote_fault, lcw_rsv, 1'b0,
                         lcw_tech, lcw_sel};
    end
  end

  // Read channel
  logic [15:0] adv_read;
  logic [15:0] status_read;
  assign adv_read = {next_page, 1'b0, remote_fault, 3'h0, 1'b0, tech,
                     selector};
  assign status_read = {8'h00, 1'b0, autoneg_active, sw_mode, fault_s,
                        FULL_CAPS};
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        ADDR_ADV:    s_axi_rdata <= {16'h0, adv_read};
        ADDR_CTRL:   s_axi_rdata <= {16'h0, ctrl_view};
        ADDR_STATUS: s_axi_rdata <= {16'h0, status_read};
        default:     s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_adv_write_locked;
    wr_adv && !override;
  endsequence
  sequence s_hw_neg;
    !sw_mode && an_pin;
  endsequence
  a_reserved_read_zero: assert property (
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_ADV) |=>
      s_axi_rdata[14] == 1'b0 && s_axi_rdata[12:9] == 4'h0 && s_axi_rvalid)
    else $error("reserved advertisement bits read nonzero");
  a_locked_write: assert property (
    s_adv_write_locked |=> $stable(rsv_hi) && $stable(selector) &&
      $stable(rsv_ack))
    else $error("override-write bits changed without override");
  a_fault_follow: assert property (
    $rose(fault_s) |=> remote_fault ##1 link_code_word[ADV_FAULT])
    else $error("remote fault not advertised");
  a_four_lane_zero: assert property (
    link_code_word[ADV_T4] == 1'b0 && adv_view[ADV_T4] == 1'b0)
    else $error("four-lane ability set");
  a_hw_onehot: assert property (
    s_hw_neg ##1 s_hw_neg |-> tech == $past(pin_onehot) && $onehot(tech))
    else $error("hardware advertisement not one pin-chosen bit");
  a_hw_readonly: assert property (
    (!sw_mode && !an_pin) [*2] |-> tech == 4'h0)
    else $error("hardware ability bits writable");
  a_status_caps: assert property (
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS) |=>
      s_axi_rdata[3:0] == FULL_CAPS)
    else $error("status capability set incomplete");
  a_idle_mode: assert property (
    (sw_mode && !an_enable) [*2] |-> idle_mode && !autoneg_active)
    else $error("negotiation not skipped");
  a_selector_sent: assert property (
    autoneg_restart |=> ##1 link_code_word[4:0] == $past(selector, 2))
    else $error("selector not sent");
  a_sw_defaults: assert property (
    disable iff (1'b0) sys_rst |=> tech == RST_TECH_SW && !next_page)
    else $error("reset defaults not loaded");
endmodule // autoneg_adv_regs

//--- testbench/station_mgmt_model.sv
// Purpose: Station management master model on the register bus
// Assumes: One write and one read under way at a time
// Notes: Released payload is inverted so stale data is never reused
`timescale 1ns/1ps
module station_mgmt_model (
  // Clock
  input  wire logic        sys_clk,
  // Write side
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [3:0]       s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  // Read side
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [3:0]       s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  initial begin
    s_axi_awvalid = 1'b0;
    s_axi_awaddr  = 4'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr  = 4'h0;
    s_axi_rready  = 1'b0;
  end

  // Address and data offered together, each released when taken
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    @(posedge sys_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // station_mgmt_model

//--- testbench/autoneg_advertisement_register_test.sv
// Purpose: Self-checking bench for the advertisement register bank
// Assumes: Pins settle within six cycles of a change
// Notes: Random register values, fixed seed
`timescale 1ns/1ps
module autoneg_advertisement_register_test;
  import autoneg_adv_pkg::*;
  logic        sys_clk, sys_rst;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        hardware_software_mode_pin, autoneg_select_pin;
  logic        rate_select_pin, duplex_select_pin, local_link_fault;
  logic [15:0] link_code_word, adv;
  logic        autoneg_active, autoneg_restart, idle_mode;
  logic        op_speed_100, op_full_duplex;
  int          miscompares = 0;
  int          comparisons = 0;

  autoneg_adv_regs dut_u (.sys_clk, .sys_rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .hardware_software_mode_pin,
    .autoneg_select_pin, .rate_select_pin, .duplex_select_pin,
    .local_link_fault, .link_code_word, .autoneg_active, .autoneg_restart,
    .idle_mode, .op_speed_100, .op_full_duplex);

  station_mgmt_model pm_u (.sys_clk, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] adv_rd(logic [15:0] s, logic f);
    return {16'h0, s[15], 1'b0, f, 4'h0, s[8:0]};
  endfunction
  function automatic logic [31:0] lcw_exp(logic [15:0] s, logic f);
    return {16'h0, s[15], 1'b0, f, s[12:10], 1'b0, s[8:0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    pm_u.bus_read(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [1:0] r;
    pm_u.bus_write(a, {16'h0, d}, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic reset_dut();
    sys_rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] v;
    sys_rst = 1'b1;
    hardware_software_mode_pin = 1'b1;
    autoneg_select_pin = 1'b0;
    rate_select_pin = 1'b0;
    duplex_select_pin = 1'b0;
    local_link_fault = 1'b0;
    void'($urandom(32'hFE179D66));
    reset_dut();
    adv = 16'h01E1;
    rd_chk(ADDR_ADV, adv_rd(adv, 1'b0));
    rd_chk(ADDR_CTRL, 32'h3100);
    rd_chk(ADDR_STATUS, {25'h0, 2'b11, 1'b0, FULL_CAPS});
    check({16'h0, link_code_word}, lcw_exp(adv, 1'b0));
    // Override clear: only the next page bit may change
    wr(ADDR_ADV, 16'h8000);
    adv[15] = 1'b1;
    rd_chk(ADDR_ADV, adv_rd(adv, 1'b0));
    wr(ADDR_CTRL, 16'hB100);
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom());
      v[14:10] = 5'h0;
      wr(ADDR_ADV, v);
      adv = v;
      adv[9] = 1'b0;
      rd_chk(ADDR_ADV, adv_rd(adv, 1'b0));
    end
    wr(ADDR_ADV, adv | 16'h5C00);
    adv = adv | 16'h1C00;
    rd_chk(ADDR_ADV, adv_rd(adv, 1'b0));
    wr(ADDR_CTRL, 16'hB300);
    check({31'h0, autoneg_restart}, 32'h1);
    @(posedge sys_clk);
    check({31'h0, autoneg_restart}, 32'h0);
    repeat (8) @(posedge sys_clk);
    check({16'h0, link_code_word}, lcw_exp(adv, 1'b0));
    local_link_fault <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check({16'h0, link_code_word}, lcw_exp(adv, 1'b1));
    rd_chk(ADDR_ADV, adv_rd(adv, 1'b1));
    local_link_fault <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({16'h0, link_code_word}, lcw_exp(adv, 1'b0));
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, {2'b10, i[1], 4'h0, i[0], 8'h0});
      check({31'h0, autoneg_restart}, 32'h0);
      repeat (3) @(posedge sys_clk);
      check({28'h0, idle_mode, op_speed_100, op_full_duplex, autoneg_active},
            {28'h0, 1'b1, i[1], i[0], 1'b0});
    end
    hardware_software_mode_pin <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      autoneg_select_pin <= i[2];
      rate_select_pin <= i[1];
      duplex_select_pin <= i[0];
      repeat (6) @(posedge sys_clk);
      v = {adv[15:9], (i[2] ? 4'h1 << i[1:0] : 4'h0), adv[4:0]};
      rd_chk(ADDR_ADV, adv_rd(v, 1'b0));
      check({16'h0, link_code_word}, lcw_exp(v, 1'b0));
      check({31'h0, idle_mode}, {31'h0, !i[2]});
      if (!i[2])
        check({30'h0, op_speed_100, op_full_duplex}, {30'h0, i[1:0]});
      rd_chk(ADDR_STATUS, {25'h0, i[2], 2'h0, FULL_CAPS});
    end
    wr(ADDR_ADV, 16'h0000);
    rd_chk(ADDR_ADV, adv_rd(16'h0100, 1'b0));
    pm_u.bus_write(4'hC, 32'h0000_1234, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    pm_u.bus_read(4'hC, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    hardware_software_mode_pin <= 1'b1;
    reset_dut();
    rd_chk(ADDR_ADV, 32'h01E1);
    check({16'h0, link_code_word}, 32'h01E1);
    report_and_stop();
  end
endmodule // autoneg_advertisement_register_test
